// ---- rcod_pkg.sv ----
// Contract
// - A software source-select register picks the clock feeding the generator.
// - Setting enable starts the output with no glitch or runt pulse; at divide-by-1 on a pin source the first high pulse is one cycle short.
// - Clearing enable stops the output at once, mid-period if need be.
// - Output rate is input divided by 1, 2, 4, 8, 16, 32, 64 or 128; on the system clock divide-by-1 gives pclk/2, as divide-by-2 does.
// - Divider changes while enabled are taken; glitches may occur then.
// - High time is duty/4 of the period, rounded down: 0%, 25%, 50% or 75% per the duty field.
// - Divide-by-one passes the input through; duty field does not apply.
// - Duty changes while enabled are taken; glitches may occur then.
// - Reset sets the upper duty bit, so the default duty is 50%.
// - The generator runs from the system clock and halts when it stops.
// - In sleep the output holds its present level until clock resumes.
// - Configuration and counter state survive sleep and resume unchanged.
`default_nettype none

package rcod_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Register map
  localparam logic [11:0] RCOD_CTRL_OFS = 12'h000;
  localparam logic [11:0] RCOD_SRC_OFS = 12'h004;
  localparam logic [11:0] RCOD_STAT_OFS = 12'h008;

  // ==========================================================
  // Control fields
  localparam int RCOD_DIV_LSB = 0;
  localparam int RCOD_DIV_W = 3;
  localparam int RCOD_DUTY_LSB = 4;
  localparam int RCOD_DUTY_W = 2;
  localparam int RCOD_EN_BIT = 7;
  localparam logic [RCOD_DIV_W-1:0] RCOD_DIV_RST = 3'h0;
  localparam logic [RCOD_DUTY_W-1:0] RCOD_DUTY_RST = 2'h2;
  localparam logic RCOD_EN_RST = 1'b0;

  // ==========================================================
  // Source select and status fields
  localparam int RCOD_SRC_W = 2;
  localparam logic [RCOD_SRC_W-1:0] RCOD_SRC_RST = 2'h0;
  localparam logic [RCOD_SRC_W-1:0] RCOD_SRC_SYSCLK = 2'h0;
  localparam int RCOD_CNT_W = 7;
  localparam int RCOD_STAT_OUT_BIT = 0;
  localparam int RCOD_STAT_RUN_BIT = 1;
  localparam int RCOD_STAT_SLP_BIT = 2;
  localparam int RCOD_STAT_CNT_LSB = 8;

endpackage : rcod_pkg

`default_nettype wire

// ---- rcod_cfg_if.sv ----
`default_nettype none

interface rcod_cfg_if;
  timeunit 1ns;
  timeprecision 1ps;
  logic enable;
  logic [rcod_pkg::RCOD_DIV_W-1:0] div;
  logic [rcod_pkg::RCOD_DUTY_W-1:0] duty;
  logic tick;
  logic hold;
  logic src_level;
  logic wave;
  logic started;
  logic [rcod_pkg::RCOD_CNT_W-1:0] count;

  modport ctl (output enable, div, duty, tick, hold, src_level,
               input wave, started, count);
  modport gen (input enable, div, duty, tick, hold, src_level,
               output wave, started, count);
endinterface : rcod_cfg_if

`default_nettype wire

// ---- rcod_gen.sv ----
`default_nettype none

module rcod_gen (
  input wire logic pclk,
  input wire logic presetn,
  rcod_cfg_if.gen cfg
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Helpers
  function automatic logic [rcod_pkg::RCOD_CNT_W:0] rcod_period(
    input logic [rcod_pkg::RCOD_DIV_W-1:0] div);
    rcod_period = (rcod_pkg::RCOD_CNT_W+1)'(1) << div;
  endfunction : rcod_period

  function automatic logic [rcod_pkg::RCOD_CNT_W:0] rcod_thr(
    input logic [rcod_pkg::RCOD_DIV_W-1:0] div,
    input logic [rcod_pkg::RCOD_DUTY_W-1:0] duty);
    logic [rcod_pkg::RCOD_CNT_W+2:0] prod;
    prod = (rcod_pkg::RCOD_CNT_W+3)'(rcod_period(div)) * (rcod_pkg::RCOD_CNT_W+3)'(duty);
    rcod_thr = prod[rcod_pkg::RCOD_CNT_W+2:2];
  endfunction : rcod_thr

  // ==========================================================
  // Counter and start flag
  logic [rcod_pkg::RCOD_CNT_W-1:0] cnt_r;
  logic [rcod_pkg::RCOD_CNT_W-1:0] cnt_nxt;
  logic started_r;
  logic started_nxt;
  logic [rcod_pkg::RCOD_CNT_W:0] mask;

  always_comb begin
    cnt_nxt = cnt_r;
    started_nxt = started_r;
    mask = rcod_period(cfg.div) - (rcod_pkg::RCOD_CNT_W+1)'(1);
    if (!cfg.enable) begin
      // Stops at once, whatever the phase
      cnt_nxt = '0;
      started_nxt = 1'b0;
    end else if (cfg.hold) begin
      cnt_nxt = cnt_r;
    end else if (cfg.tick) begin
      // The first tick after enable opens a full period at count zero
      if (!started_r) begin
        started_nxt = 1'b1;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = (cnt_r + rcod_pkg::RCOD_CNT_W'(1)) & mask[rcod_pkg::RCOD_CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      started_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      started_r <= started_nxt;
    end
  end

  // ==========================================================
  // Waveform; config read live, so changes while enabled may glitch
  always_comb begin
    cfg.wave = 1'b0;
    if (cfg.enable && started_r) begin
      if (cfg.div == rcod_pkg::RCOD_DIV_W'(0)) begin
        cfg.wave = cfg.src_level;
      end else begin
        cfg.wave = ({1'b0, cnt_r} < rcod_thr(cfg.div, cfg.duty));
      end
    end
  end

  assign cfg.started = started_r;
  assign cfg.count = cnt_r;

endmodule : rcod_gen

`default_nettype wire

// ---- rcod_top.sv ----
`default_nettype none

module rcod_top #(
  parameter int NUM_SRC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:1] refclk_src_in,
  input wire logic sleep_req,
  output logic refclk_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Address decode
  function automatic logic rcod_hit(input logic [11:0] addr, input logic [11:0] ofs);
    rcod_hit = (addr[11:2] == ofs[11:2]);
  endfunction : rcod_hit

  // ==========================================================
  // Configuration registers
  logic en_r;
  logic en_nxt;
  logic [rcod_pkg::RCOD_DIV_W-1:0] div_r;
  logic [rcod_pkg::RCOD_DIV_W-1:0] div_nxt;
  logic [rcod_pkg::RCOD_DUTY_W-1:0] duty_r;
  logic [rcod_pkg::RCOD_DUTY_W-1:0] duty_nxt;
  logic [rcod_pkg::RCOD_SRC_W-1:0] src_r;
  logic [rcod_pkg::RCOD_SRC_W-1:0] src_nxt;

  // ==========================================================
  // APB slave: one wait state so every answer comes from a flop
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic access;
  logic commit;
  logic mapped;
  logic [31:0] rd_word;
  logic out_r;
  logic out_nxt;
  rcod_cfg_if cfg ();

  assign access = psel && penable;
  assign commit = access && pready_r;
  assign mapped = rcod_hit(paddr, rcod_pkg::RCOD_CTRL_OFS)
                  || rcod_hit(paddr, rcod_pkg::RCOD_SRC_OFS)
                  || rcod_hit(paddr, rcod_pkg::RCOD_STAT_OFS);

  always_comb begin
    rd_word = '0;
    if (rcod_hit(paddr, rcod_pkg::RCOD_CTRL_OFS)) begin
      rd_word[rcod_pkg::RCOD_EN_BIT] = en_r;
      rd_word[rcod_pkg::RCOD_DUTY_LSB +: rcod_pkg::RCOD_DUTY_W] = duty_r;
      rd_word[rcod_pkg::RCOD_DIV_LSB +: rcod_pkg::RCOD_DIV_W] = div_r;
    end else if (rcod_hit(paddr, rcod_pkg::RCOD_SRC_OFS)) begin
      rd_word[rcod_pkg::RCOD_SRC_W-1:0] = src_r;
    end else if (rcod_hit(paddr, rcod_pkg::RCOD_STAT_OFS)) begin
      rd_word[rcod_pkg::RCOD_STAT_OUT_BIT] = out_r;
      rd_word[rcod_pkg::RCOD_STAT_RUN_BIT] = cfg.started;
      rd_word[rcod_pkg::RCOD_STAT_SLP_BIT] = sleep_req;
      rd_word[rcod_pkg::RCOD_STAT_CNT_LSB +: rcod_pkg::RCOD_CNT_W] = cfg.count;
    end
  end

  always_comb begin
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (access && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_comb begin
    en_nxt = en_r;
    div_nxt = div_r;
    duty_nxt = duty_r;
    src_nxt = src_r;
    if (commit && pwrite) begin
      if (rcod_hit(paddr, rcod_pkg::RCOD_CTRL_OFS)) begin
        en_nxt = pwdata[rcod_pkg::RCOD_EN_BIT];
        div_nxt = pwdata[rcod_pkg::RCOD_DIV_LSB +: rcod_pkg::RCOD_DIV_W];
        duty_nxt = pwdata[rcod_pkg::RCOD_DUTY_LSB +: rcod_pkg::RCOD_DUTY_W];
      end else if (rcod_hit(paddr, rcod_pkg::RCOD_SRC_OFS)) begin
        src_nxt = pwdata[rcod_pkg::RCOD_SRC_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      en_r <= rcod_pkg::RCOD_EN_RST;
      div_r <= rcod_pkg::RCOD_DIV_RST;
      duty_r <= rcod_pkg::RCOD_DUTY_RST;
      src_r <= rcod_pkg::RCOD_SRC_RST;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      en_r <= en_nxt;
      div_r <= div_nxt;
      duty_r <= duty_nxt;
      src_r <= src_nxt;
    end
  end

  // ==========================================================
  // Source synchronisers; each pin passes two flops before use
  logic [NUM_SRC-1:1] meta_r;
  logic [NUM_SRC-1:1] sync_r;
  logic [NUM_SRC-1:1] prev_r;
  logic [NUM_SRC-1:1] rise;
  logic sys_tgl_r;
  logic sys_tgl_nxt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      sys_tgl_r <= 1'b0;
    end else begin
      meta_r <= refclk_src_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      sys_tgl_r <= sys_tgl_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < NUM_SRC; gi++) begin : g_edge
      assign rise[gi] = sync_r[gi] && !prev_r[gi];
    end
  endgenerate

  // System clock cannot leave a flop at full rate; it shows as pclk/2
  assign sys_tgl_nxt = cfg.hold ? sys_tgl_r : !sys_tgl_r;

  // ==========================================================
  // Source selection
  always_comb begin
    cfg.tick = 1'b0;
    cfg.src_level = 1'b0;
    if (src_r == rcod_pkg::RCOD_SRC_SYSCLK) begin
      cfg.tick = 1'b1;
      cfg.src_level = sys_tgl_r;
    end else if (int'(src_r) < NUM_SRC) begin
      cfg.tick = rise[src_r];
      cfg.src_level = sync_r[src_r];
    end
  end

  assign cfg.enable = en_r;
  assign cfg.div = div_r;
  assign cfg.duty = duty_r;
  assign cfg.hold = sleep_req;

  rcod_gen u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg)
  );

  // ==========================================================
  // Output flop; sleep freezes the level, disable forces low at once
  always_comb begin
    out_nxt = cfg.wave;
    if (en_r && sleep_req) begin
      out_nxt = out_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign refclk_out = out_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : rcod_top

`default_nettype wire

// ---- rcod_sink.sv ----
`default_nettype none
// ==========
// Clock consumer: measures high time and period, supplies a slow source
module rcod_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic refclk_out,
  output logic src_clk,
  output logic [31:0] hi_len,
  output logic [31:0] per_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_r;
  logic prev_r;
  logic [31:0] cnt_r, hcnt_r;
  // External source, one rising edge every 4 cycles
  assign src_clk = div_r[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      prev_r <= 1'b0;
      cnt_r <= 32'h0;
      hcnt_r <= 32'h0;
      hi_len <= 32'h0;
      per_len <= 32'h0;
    end else begin
      div_r <= div_r + 2'h1;
      prev_r <= refclk_out;
      cnt_r <= cnt_r + 32'h1;
      if (refclk_out) hcnt_r <= hcnt_r + 32'h1;
      // Rise to rise is one period; the count restarts at each rise
      if (refclk_out && !prev_r) begin
        per_len <= cnt_r;
        cnt_r <= 32'h1;
        hcnt_r <= 32'h1;
      end
      if (!refclk_out && prev_r) hi_len <= hcnt_r;
    end
  end
endmodule : rcod_sink
`default_nettype wire

// ---- rcod_chk.sv ----
`default_nettype none
module rcod_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_req,
  input wire logic refclk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_ctrl, en_sh_r, en_sh_nxt;
  assign wr_ctrl = psel && penable && pready && pwrite && !pslverr && paddr[11:2] == 10'h000;
  always_comb begin
    en_sh_nxt = wr_ctrl ? pwdata[rcod_pkg::RCOD_EN_BIT] : en_sh_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_sh_r <= 1'b0;
    else en_sh_r <= en_sh_nxt;
  end
  // ==========
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property (pready && paddr[11:2] > 10'h002 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (pready && paddr[11:2] <= 10'h002 |-> !pslverr)
    else $error("mapped access refused");
  stop_now_a: assert property (wr_ctrl && !pwdata[7] |-> ##2 (!refclk_out) [*3])
    else $error("output not stopped after disable");
  idle_low_a: assert property (!en_sh_r && !$past(en_sh_r) && !$past(en_sh_r, 2) |-> !refclk_out)
    else $error("output high while disabled");
  start_low_a: assert property ($rose(en_sh_r) |-> !refclk_out)
    else $error("runt at start");
  sleep_hold_a: assert property (sleep_req && $past(sleep_req) |-> $stable(refclk_out))
    else $error("output moved in sleep");
  cover property (wr_ctrl && pwdata[7]);
  cover property (sleep_req && refclk_out);
  cover property (pready && pslverr);
endmodule : rcod_chk
bind rcod_top rcod_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_req(sleep_req), .refclk_out(refclk_out));
`default_nettype wire

// ---- reference_clock_output_divider_bench.sv ----
`default_nettype none
module reference_clock_output_divider_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, sleep_req, pready, pslverr, refclk_out, src_clk;
  logic rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, hi_len, per_len, snap;
  int failures, check_count;
  rcod_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refclk_src_in({src_clk, ~src_clk, src_clk}), .sleep_req(sleep_req),
    .refclk_out(refclk_out));
  rcod_sink i_sink (.pclk(pclk), .presetn(presetn), .refclk_out(refclk_out),
    .src_clk(src_clk), .hi_len(hi_len), .per_len(per_len));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic conclude();
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // ==========
  // APB master; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      conclude();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [31:0] ctl(input int en, input int dc, input int dv);
    return (32'(en) << rcod_pkg::RCOD_EN_BIT) | (32'(dc) << rcod_pkg::RCOD_DUTY_LSB) | 32'(dv);
  endfunction : ctl
  // Several periods pass so the consumer has a full measurement
  task automatic wait_chk(input int per, input int hi);
    repeat (3 * per + 6) @(posedge pclk);
    chk(per_len, 32'(per));
    chk(hi_len, 32'(hi));
  endtask : wait_chk
  initial begin
    int hi;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleep_req = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, rcod_pkg::RCOD_CTRL_OFS, 32'h0);
    chk(rdata, 32'h00000020);
    apb(1'b0, rcod_pkg::RCOD_SRC_OFS, 32'h0);
    chk(rdata, 32'h00000000);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, rcod_pkg::RCOD_STAT_OFS, 32'hFFFFFFFF);
    chk({31'h0, rerr}, 32'h0);
    for (int d = 0; d < 8; d++) begin
      for (int dc = 0; dc < 4; dc++) begin
        apb(1'b1, rcod_pkg::RCOD_CTRL_OFS, ctl(0, dc, d));
        apb(1'b1, rcod_pkg::RCOD_CTRL_OFS, ctl(1, dc, d));
        hi = (d == 0) ? 1 : ((1 << d) * dc) / 4;
        if (hi > 0) wait_chk((d == 0) ? 2 : (1 << d), hi);
        else repeat (8) begin
          @(posedge pclk);
          chk({31'h0, refclk_out}, 32'h0);
        end
      end
    end
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, rcod_pkg::RCOD_CTRL_OFS, ctl(0, 2, 1));
      apb(1'b1, rcod_pkg::RCOD_SRC_OFS, 32'(s));
      apb(1'b0, rcod_pkg::RCOD_SRC_OFS, 32'h0);
      chk(rdata, 32'(s));
      apb(1'b1, rcod_pkg::RCOD_CTRL_OFS, ctl(1, 2, 1));
      wait_chk(8, 4);
    end
    apb(1'b1, rcod_pkg::RCOD_SRC_OFS, 32'h0);
    apb(1'b1, rcod_pkg::RCOD_CTRL_OFS, ctl(1, 2, 7));
    repeat (70) @(posedge pclk);
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, rcod_pkg::RCOD_STAT_OFS, 32'h0);
    snap = rdata;
    chk({31'h0, snap[rcod_pkg::RCOD_STAT_SLP_BIT]}, 32'h1);
    chk({31'h0, snap[rcod_pkg::RCOD_STAT_RUN_BIT]}, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, rcod_pkg::RCOD_STAT_OFS, 32'h0);
    chk(rdata, snap);
    chk({31'h0, refclk_out}, {31'h0, snap[rcod_pkg::RCOD_STAT_OUT_BIT]});
    sleep_req <= 1'b0;
    // A live divider change may glitch until the counter wraps
    apb(1'b1, rcod_pkg::RCOD_CTRL_OFS, ctl(1, 2, 2));
    repeat (130) @(posedge pclk);
    wait_chk(4, 2);
    conclude();
  end
endmodule : reference_clock_output_divider_bench
`default_nettype wire
